// ### verilog/bsd_slave_decoder.sv
// Address and command decoder for an accessory bus slave.
// Assumes a byte receiver and sender on mclk that handle bit timing.
`timescale 1ns/1ps

module bsd_slave_decoder #(
  parameter bit OEM_EXT = 1'b0
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            nrst,
  // Address strap pins
  input  wire logic [7:0]      homeAddrPin,
  // Received message bytes
  input  wire bsd_pkg::bsd_rx_t rxIn,
  // Reply bytes
  output bsd_pkg::bsd_tx_t     txOut,
  input  wire logic            txReady,
  // Peripheral state read back
  input  wire logic [4:0]      statusIn,
  input  wire logic [7:0]      configIn,
  input  wire logic [7:0]      swCommitIn,
  input  wire logic [7:0]      swUncommIn,
  // Control outputs
  output logic                 standby,
  output logic                 resetFlag,
  output logic                 contention,
  output logic                 ctlReset,
  output logic [7:0]           curAddr
);

  bsd_pkg::bsd_core_t s_reg;
  bsd_pkg::bsd_core_t s_next;
  logic               addrHit;
  logic               accept;
  logic [2:0]         idx;
  logic               parOk;
  logic               frmOk;
  logic               wantReply;
  logic               doReply;
  logic               twoBytes;
  logic [7:0]         frmOut;
  logic [7:0]         datOut;
  logic [7:0]         statusByte;

  // ----------------------------------------------------------------------
  // Address matching
  // ----------------------------------------------------------------------
  bsd_addr_match #(
    .OEM_EXT (OEM_EXT)
  ) uMatch (
    .rxAddr  (s_reg.adr),
    .curAddr (s_reg.curAddr),
    .homeFam (s_reg.homeFam),
    .hit     (addrHit)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.ctlReset = 1'b0;
    accept          = 1'b0;
    idx             = s_reg.cnt;
    parOk           = 1'b0;
    frmOk           = 1'b0;
    wantReply       = 1'b0;
    doReply         = 1'b0;
    twoBytes        = 1'b0;
    frmOut          = bsd_pkg::FRM_OK;
    datOut          = 8'h00;
    statusByte      = {statusIn, 3'h0};
    statusByte[bsd_pkg::ST_BIT_RST]  = s_reg.resetFlag;
    statusByte[bsd_pkg::ST_BIT_STBY] = s_reg.standby;
    statusByte[bsd_pkg::ST_BIT_CONT] = s_reg.contention;

    // Strap pins are synchronised, then caught after reset release and again on each reset command.
    s_next.home1 = homeAddrPin;
    s_next.home2 = s_reg.home1;
    if (!s_reg.strapped) begin
      if (s_reg.strapCnt == bsd_pkg::STRAP_WAIT) begin
        s_next.strapped = 1'b1;
        s_next.curAddr  = s_reg.home2;
        s_next.homeFam  = s_reg.home2[7:4];
      end else begin
        s_next.strapCnt = s_reg.strapCnt + 2'h1;
      end
    end

    case (s_reg.st)
      bsd_pkg::ST_EXEC: begin
        s_next.st = bsd_pkg::ST_IDLE;
        frmOk     = (s_reg.frm[7:2] == bsd_pkg::FRM_CMD_TOP);
        wantReply = s_reg.frm[bsd_pkg::FRM_REPLY_BIT];
        if (s_reg.strapped && frmOk && s_reg.cnt >= bsd_pkg::LEN_SHORT &&
            addrHit) begin
          if (s_reg.parErr) begin
            frmOut  = bsd_pkg::FRM_PAR_ERR;
            doReply = 1'b1;
          end else begin
            doReply = 1'b1;
            // Reset is mandatory at the lowest level; the rest is decoded
            // in full so that every listed code has a defined effect.
            case (s_reg.cmd)
              bsd_pkg::CMD_RESET: begin
                s_next.standby    = bsd_pkg::RST_STANDBY;
                s_next.contention = bsd_pkg::RST_CONT;
                s_next.curAddr    = s_reg.home2;
                s_next.homeFam    = s_reg.home2[7:4];
                s_next.resetFlag  = 1'b1;
                s_next.ctlReset   = 1'b1;
              end
              bsd_pkg::CMD_CLR_RESET: begin
                s_next.resetFlag = 1'b0;
              end
              bsd_pkg::CMD_STANDBY: begin
                s_next.standby = 1'b1;
              end
              bsd_pkg::CMD_POWER_ON: begin
                s_next.standby = 1'b0;
              end
              bsd_pkg::CMD_SET_CONT: begin
                s_next.contention = 1'b1;
              end
              bsd_pkg::CMD_ADDR_CONT: begin
                doReply  = s_reg.contention;
                twoBytes = 1'b1;
                datOut   = s_reg.curAddr;
              end
              bsd_pkg::CMD_CLR_CONT: begin
                s_next.contention = 1'b0;
              end
              bsd_pkg::CMD_ADDR_FREE: begin
                doReply  = !s_reg.contention;
                twoBytes = 1'b1;
                datOut   = s_reg.curAddr;
              end
              bsd_pkg::CMD_MOVE_CONT: begin
                if (s_reg.cnt < bsd_pkg::LEN_LONG) begin
                  frmOut = bsd_pkg::FRM_NOT_RECOG;
                end else if (s_reg.contention) begin
                  s_next.curAddr = s_reg.dat;
                end
              end
              bsd_pkg::CMD_MOVE_FREE: begin
                if (s_reg.cnt < bsd_pkg::LEN_LONG) begin
                  frmOut = bsd_pkg::FRM_NOT_RECOG;
                end else if (!s_reg.contention) begin
                  s_next.curAddr = s_reg.dat;
                end
              end
              bsd_pkg::CMD_STATUS: begin
                twoBytes = 1'b1;
                datOut   = statusByte;
              end
              bsd_pkg::CMD_CONFIG: begin
                twoBytes = 1'b1;
                datOut   = configIn;
              end
              bsd_pkg::CMD_SW_COMMIT: begin
                twoBytes = 1'b1;
                datOut   = swCommitIn;
              end
              bsd_pkg::CMD_SW_UNCOMM: begin
                twoBytes = 1'b1;
                datOut   = swUncommIn;
              end
              default: begin
                frmOut = bsd_pkg::FRM_NOT_SUPP;
              end
            endcase
          end
          if (doReply && wantReply) begin
            s_next.st        = bsd_pkg::ST_REPLY;
            s_next.tx.valid  = 1'b1;
            s_next.tx.data   = frmOut;
            s_next.tx.parity = ~^frmOut;
            s_next.tx.last   = !(twoBytes && frmOut == bsd_pkg::FRM_OK);
            s_next.replyDat  = datOut;
          end
        end
      end

      bsd_pkg::ST_REPLY: begin
        if (txReady) begin
          if (s_reg.tx.last) begin
            s_next.tx.valid = 1'b0;
            s_next.tx.last  = 1'b0;
            s_next.st       = bsd_pkg::ST_IDLE;
          end else begin
            s_next.tx.data   = s_reg.replyDat;
            s_next.tx.parity = ~^s_reg.replyDat;
            s_next.tx.last   = 1'b1;
          end
        end
      end

      default: begin
        if (rxIn.start) begin
          s_next.st     = bsd_pkg::ST_COLLECT;
          s_next.cnt    = bsd_pkg::IDX_FRAMING;
          s_next.parErr = 1'b0;
          idx           = bsd_pkg::IDX_FRAMING;
        end
        accept = rxIn.valid && (rxIn.start ||
                 s_reg.st == bsd_pkg::ST_COLLECT);
        if (accept) begin
          parOk = ^{rxIn.data, rxIn.parity};
          if (!parOk) begin
            s_next.parErr = 1'b1;
          end
          if (idx == bsd_pkg::IDX_FRAMING) begin
            s_next.frm = rxIn.data;
          end else if (idx == bsd_pkg::IDX_ADDR) begin
            s_next.adr = rxIn.data;
          end else if (idx == bsd_pkg::IDX_CMD) begin
            s_next.cmd = rxIn.data;
          end else if (idx == bsd_pkg::IDX_DATA) begin
            s_next.dat = rxIn.data;
          end
          if (idx != bsd_pkg::IDX_OVER) begin
            s_next.cnt = idx + 3'h1;
          end
        end
        if (rxIn.stop && (rxIn.start ||
            s_reg.st == bsd_pkg::ST_COLLECT)) begin
          s_next.st = bsd_pkg::ST_EXEC;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_reg            <= '0;
      s_reg.st         <= bsd_pkg::ST_IDLE;
      s_reg.standby    <= bsd_pkg::RST_STANDBY;
      s_reg.resetFlag  <= bsd_pkg::RST_RFLAG;
      s_reg.contention <= bsd_pkg::RST_CONT;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign txOut      = s_reg.tx;
  assign standby    = s_reg.standby;
  assign resetFlag  = s_reg.resetFlag;
  assign contention = s_reg.contention;
  assign ctlReset   = s_reg.ctlReset;
  assign curAddr    = s_reg.curAddr;

endmodule

// ### verilog/bsd_pkg.sv
// Constants and carrier types for the accessory bus address and command
// decoder.
// Assumes one clock domain and a byte receiver on the same clock.
//
// Notes on behaviour
// - Address high nibble family, low nibble sub-type.
// - Address zero reaches every slave.
// - Own family with sub-type zero is broadcast.
// - Respond to the slave's own specific address.
// - Family six holds reallocated addresses; match them.
// - Family fifteen is never ours without extension.
// - Code 00 resets logic; 01 clears reset flag.
// - Code 02 enters standby; 03 powers on.
// - Code 04 sets contention; 05 replies if set.
// - Code 06 clears contention; 07 replies if clear.
// - Code 08 changes address when contention set.
// - Code 09 changes address when contention clear.
// - Code 10 replies status; 11 replies configuration.
// - Codes 14, 15 reply switch states; 16, 17 reserved.
// - Reply data follows the reply framing byte.
// - Implement every mandatory command of the level.
// - Unsupported command answers not-supported framing byte.
// - Reply only when framing byte requests one.
// - Every byte carries one odd parity bit.
package bsd_pkg;

  // ----------------------------------------------------------------------
  // Framing bytes
  // ----------------------------------------------------------------------
  localparam logic [5:0] FRM_CMD_TOP   = 6'h38;
  localparam logic [7:0] FRM_OK        = 8'he4;
  localparam logic [7:0] FRM_NOT_SUPP  = 8'he5;
  localparam logic [7:0] FRM_PAR_ERR   = 8'he6;
  localparam logic [7:0] FRM_NOT_RECOG = 8'he7;
  localparam int         FRM_REPLY_BIT = 1;

  // ----------------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ALL    = 8'h00;
  localparam logic [3:0] SUB_BCAST   = 4'h0;
  localparam logic [3:0] FAM_REALLOC = 4'h6;
  localparam logic [3:0] FAM_OEM     = 4'hf;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_RESET      = 8'h00;
  localparam logic [7:0] CMD_CLR_RESET  = 8'h01;
  localparam logic [7:0] CMD_STANDBY    = 8'h02;
  localparam logic [7:0] CMD_POWER_ON   = 8'h03;
  localparam logic [7:0] CMD_SET_CONT   = 8'h04;
  localparam logic [7:0] CMD_ADDR_CONT  = 8'h05;
  localparam logic [7:0] CMD_CLR_CONT   = 8'h06;
  localparam logic [7:0] CMD_ADDR_FREE  = 8'h07;
  localparam logic [7:0] CMD_MOVE_CONT  = 8'h08;
  localparam logic [7:0] CMD_MOVE_FREE  = 8'h09;
  localparam logic [7:0] CMD_STATUS     = 8'h10;
  localparam logic [7:0] CMD_CONFIG     = 8'h11;
  localparam logic [7:0] CMD_SW_COMMIT  = 8'h14;
  localparam logic [7:0] CMD_SW_UNCOMM  = 8'h15;

  // ----------------------------------------------------------------------
  // Message positions, counts and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] IDX_FRAMING = 3'h0;
  localparam logic [2:0] IDX_ADDR    = 3'h1;
  localparam logic [2:0] IDX_CMD     = 3'h2;
  localparam logic [2:0] IDX_DATA    = 3'h3;
  localparam logic [2:0] IDX_OVER    = 3'h4;
  localparam logic [2:0] LEN_SHORT   = 3'h3;
  localparam logic [2:0] LEN_LONG    = 3'h4;
  localparam logic [1:0] STRAP_WAIT  = 2'h2;
  localparam int         ST_BIT_RST  = 0;
  localparam int         ST_BIT_STBY = 1;
  localparam int         ST_BIT_CONT = 2;
  localparam logic       RST_STANDBY = 1'b0;
  localparam logic       RST_RFLAG   = 1'b1;
  localparam logic       RST_CONT    = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_EXEC,
    ST_REPLY
  } bsd_state_t;

  typedef struct packed {
    logic       start;
    logic       valid;
    logic [7:0] data;
    logic       parity;
    logic       stop;
  } bsd_rx_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
    logic       parity;
  } bsd_tx_t;

  typedef struct packed {
    bsd_state_t st;
    logic [2:0] cnt;
    logic       parErr;
    logic [7:0] frm;
    logic [7:0] adr;
    logic [7:0] cmd;
    logic [7:0] dat;
    logic [7:0] replyDat;
    logic [7:0] home1;
    logic [7:0] home2;
    logic [1:0] strapCnt;
    logic       strapped;
    logic [3:0] homeFam;
    logic [7:0] curAddr;
    logic       standby;
    logic       resetFlag;
    logic       contention;
    logic       ctlReset;
    bsd_tx_t    tx;
  } bsd_core_t;

endpackage

// ### verilog/bsd_addr_match.sv
// Address byte matcher for the accessory bus slave.
// Assumes the slave's current address and home family are stable flops.
`timescale 1ns/1ps

module bsd_addr_match #(
  parameter bit OEM_EXT = 1'b0
) (
  // Received address
  input  wire logic [7:0] rxAddr,
  // Slave identity
  input  wire logic [7:0] curAddr,
  input  wire logic [3:0] homeFam,
  // Result
  output logic            hit
);

  logic [3:0] rxFam;
  logic [3:0] rxSub;
  logic       ownOk;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  always_comb begin
    rxFam = rxAddr[7:4];
    rxSub = rxAddr[3:0];
    ownOk = (curAddr[7:4] != bsd_pkg::FAM_OEM) || OEM_EXT;
    hit   = 1'b0;
    if (rxAddr == bsd_pkg::ADDR_ALL) begin
      hit = 1'b1;
    end else if (rxFam == bsd_pkg::FAM_OEM && !OEM_EXT) begin
      hit = 1'b0;
    end else if (rxSub == bsd_pkg::SUB_BCAST && rxFam == homeFam) begin
      hit = 1'b1;
    end else if (rxAddr == curAddr && ownOk) begin
      hit = 1'b1;
    end
  end

endmodule

// ### testbench/bsd_master_model.sv
// Bus master model: sends message bytes and takes reply bytes.
// Assumes the decoder samples its inputs on the rising edge of mclk.
`timescale 1ns/1ps

module bsd_master_model (
  input  wire logic             mclk,
  input  wire bsd_pkg::bsd_tx_t txOut,
  output bsd_pkg::bsd_rx_t      rxIn,
  output logic                  txReady
);
  logic [8:0] replyQ[$];
  logic       slow;
  logic       gotLast;

  initial begin
    rxIn    = '0;
    slow    = 1'b0;
    gotLast = 1'b0;
  end

  // A slow master drops txReady every other cycle.
  always @(negedge mclk) begin
    txReady <= slow ? ~txReady : 1'b1;
  end

  always @(posedge mclk) begin
    if (txOut.valid && txReady) begin
      replyQ.push_back({txOut.parity, txOut.data});
      if (txOut.last) begin
        gotLast = 1'b1;
      end
    end
  end

  // Sends the first n of the framing, address, command and data bytes, then waits for a reply.
  task automatic msg(input logic [7:0] frm, adr, cmd, dat,
                     input int n, input bit perr);
    logic [7:0] b[4];
    b = '{frm, adr, cmd, dat};
    replyQ.delete();
    gotLast = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      rxIn.start  <= (i == 0);
      rxIn.valid  <= 1'b1;
      rxIn.data   <= b[i];
      rxIn.parity <= ~^b[i] ^ (perr && i == 2);
      rxIn.stop   <= (i == n - 1);
    end
    @(negedge mclk);
    rxIn.start <= 1'b0;
    rxIn.valid <= 1'b0;
    rxIn.stop  <= 1'b0;
    rxIn.data  <= ~rxIn.data;
    for (int k = 0; k < 20 && !gotLast; k++) begin
      @(negedge mclk);
    end
  endtask
endmodule

// ### testbench/bsd_slave_decoder_chk.sv
// Checker for the decoder's reply and flag timing.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps

module bsd_slave_decoder_chk #(
  parameter bit OEM_EXT = 1'b0
) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             nrst,
  // Inputs
  input wire logic [7:0]       homeAddrPin,
  input wire bsd_pkg::bsd_rx_t rxIn,
  input wire logic             txReady,
  input wire logic [4:0]       statusIn,
  input wire logic [7:0]       configIn,
  input wire logic [7:0]       swCommitIn,
  input wire logic [7:0]       swUncommIn,
  // Outputs
  input wire bsd_pkg::bsd_tx_t txOut,
  input wire logic             standby,
  input wire logic             resetFlag,
  input wire logic             contention,
  input wire logic             ctlReset,
  input wire logic [7:0]       curAddr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_tx_parity_odd:
    assert property (txOut.valid |-> ^{txOut.data, txOut.parity})
    else $error("Reply parity is not odd.");
  a_tx_hold_byte:
    assert property (txOut.valid && !txReady |=> txOut.valid
      && $stable(txOut.data)) else $error("Reply byte not held.");
  a_last_ends_reply:
    assert property (txOut.valid && txOut.last && txReady |=> !txOut.valid)
    else $error("Reply runs past its last byte.");
  a_reply_after_stop:
    assert property ($rose(txOut.valid) |-> $past(rxIn.stop, 2)
      || $past(rxIn.stop, 3) || $past(rxIn.stop, 4))
    else $error("Reply without a message.");
  a_reply_framing:
    assert property ($rose(txOut.valid) |-> txOut.data[7:2] == 6'h39)
    else $error("First reply byte is not a framing byte.");
  a_error_single:
    assert property ($rose(txOut.valid) && txOut.data != bsd_pkg::FRM_OK
      |-> txOut.last) else $error("Error reply is not single.");
  a_standby_cause:
    assert property ($changed(standby) |-> $past(rxIn.stop, 2)
      || $past(rxIn.stop, 3) || $past(rxIn.stop, 4))
    else $error("Standby changed without a command.");
  a_cont_cause:
    assert property ($changed(contention) |-> $past(rxIn.stop, 2)
      || $past(rxIn.stop, 3) || $past(rxIn.stop, 4))
    else $error("Contention changed without a command.");
  a_ctl_pulse:
    assert property (ctlReset |=> !ctlReset)
    else $error("Control reset longer than one cycle.");
  a_ctl_restores:
    assert property ($rose(ctlReset) |-> ##[0:2] (resetFlag && !standby
      && !contention && curAddr == homeAddrPin))
    else $error("Reset command did not restore state.");
endmodule

// ### testbench/bsd_slave_decoder_test.sv
// Testbench for the accessory bus address and command decoder.
// Assumes the master model drives messages and takes replies.
`timescale 1ns/1ps

module bsd_slave_decoder_test;
  logic             mclk = 1'b0;
  logic             nrst = 1'b0;
  bsd_pkg::bsd_rx_t rxIn;
  bsd_pkg::bsd_tx_t txOut;
  logic             txReady;
  logic             standby, resetFlag, contention, ctlReset;
  logic [7:0]       curAddr;
  int               errors = 0;
  int               checks_done = 0;
  int               ctlPulses = 0;

  always #12.5 mclk = ~mclk;

  // Counts the cycles in which the control reset pulse stands.
  always @(posedge mclk) begin
    if (ctlReset === 1'b1) begin
      ctlPulses++;
    end
  end

  bsd_slave_decoder dut (.mclk(mclk), .nrst(nrst),
    .homeAddrPin(8'h11), .rxIn(rxIn), .txOut(txOut), .txReady(txReady),
    .statusIn(5'h15), .configIn(8'ha3), .swCommitIn(8'h5c),
    .swUncommIn(8'hc5), .standby(standby), .resetFlag(resetFlag),
    .contention(contention), .ctlReset(ctlReset), .curAddr(curAddr));
  bsd_master_model m (.mclk(mclk), .txOut(txOut), .rxIn(rxIn),
    .txReady(txReady));

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic run(input logic [7:0] frm, adr, cmd, dat, input int n,
                     input bit perr, input int rn, input logic [7:0] r0, r1);
    m.msg(frm, adr, cmd, dat, n, perr);
    chk("reply count", 8'(rn), 8'(m.replyQ.size()));
    for (int i = 0; i < rn && i < m.replyQ.size(); i++) begin
      chk("reply byte", i ? r1 : r0, m.replyQ[i][7:0]);
      chk("reply parity", 8'h01, 8'(^m.replyQ[i]));
    end
  endtask

  initial begin
    #100000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    repeat (5) @(negedge mclk);
    chk("curAddr", 8'h11, curAddr);
    chk("resetFlag", 8'h01, 8'(resetFlag));
    chk("standby", 8'h00, 8'(standby));
    chk("contention", 8'h00, 8'(contention));
    m.slow = 1'b1;
    run(8'he2, 8'h11, 8'h10, 8'h00, 3, 0, 2, 8'he4, 8'ha9);
    m.slow = 1'b0;
    run(8'he0, 8'h11, 8'h01, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    chk("resetFlag", 8'h00, 8'(resetFlag));
    run(8'he0, 8'h10, 8'h02, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    chk("standby", 8'h01, 8'(standby));
    run(8'he0, 8'h00, 8'h03, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    chk("standby", 8'h00, 8'(standby));
    run(8'he3, 8'h11, 8'h11, 8'h00, 3, 0, 2, 8'he4, 8'ha3);
    run(8'he2, 8'h11, 8'h14, 8'h00, 3, 0, 2, 8'he4, 8'h5c);
    run(8'he2, 8'h11, 8'h15, 8'h00, 3, 0, 2, 8'he4, 8'hc5);
    run(8'he2, 8'h11, 8'h16, 8'h00, 3, 0, 1, 8'he5, 8'h00);
    run(8'he2, 8'h11, 8'h17, 8'h00, 3, 0, 1, 8'he5, 8'h00);
    run(8'he2, 8'h11, 8'h0f, 8'h00, 3, 0, 1, 8'he5, 8'h00);
    run(8'he2, 8'h22, 8'h10, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    run(8'he2, 8'hf1, 8'h10, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    run(8'he0, 8'h11, 8'h10, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    run(8'he2, 8'h11, 8'h07, 8'h00, 3, 0, 2, 8'he4, 8'h11);
    run(8'he0, 8'h11, 8'h04, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    chk("contention", 8'h01, 8'(contention));
    run(8'he2, 8'h11, 8'h07, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    run(8'he2, 8'h11, 8'h05, 8'h00, 3, 0, 2, 8'he4, 8'h11);
    run(8'he0, 8'h11, 8'h09, 8'h62, 4, 0, 0, 8'h00, 8'h00);
    chk("curAddr", 8'h11, curAddr);
    run(8'he0, 8'h11, 8'h08, 8'h62, 4, 0, 0, 8'h00, 8'h00);
    chk("curAddr", 8'h62, curAddr);
    run(8'he2, 8'h62, 8'h10, 8'h00, 3, 0, 2, 8'he4, 8'hac);
    run(8'he2, 8'h10, 8'h10, 8'h00, 3, 0, 2, 8'he4, 8'hac);
    run(8'he0, 8'h62, 8'h06, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    chk("contention", 8'h00, 8'(contention));
    run(8'he2, 8'h62, 8'h05, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    run(8'he2, 8'h62, 8'h09, 8'h63, 4, 0, 1, 8'he4, 8'h00);
    chk("curAddr", 8'h63, curAddr);
    run(8'he2, 8'h63, 8'h10, 8'h00, 3, 1, 1, 8'he6, 8'h00);
    run(8'he2, 8'h63, 8'h08, 8'h00, 3, 0, 1, 8'he7, 8'h00);
    run(8'he2, 8'h63, 8'h00, 8'h00, 3, 0, 1, 8'he4, 8'h00);
    chk("curAddr", 8'h11, curAddr);
    chk("resetFlag", 8'h01, 8'(resetFlag));
    chk("ctlReset pulses", 8'h01, 8'(ctlPulses));
    run(8'he0, 8'h11, 8'h09, 8'hf1, 4, 0, 0, 8'h00, 8'h00);
    chk("curAddr", 8'hf1, curAddr);
    run(8'he2, 8'hf1, 8'h10, 8'h00, 3, 0, 0, 8'h00, 8'h00);
    run(8'he2, 8'h00, 8'h00, 8'h00, 3, 0, 1, 8'he4, 8'h00);
    chk("curAddr", 8'h11, curAddr);
    chk("ctlReset pulses", 8'h02, 8'(ctlPulses));
    give_verdict();
  end
endmodule

bind bsd_slave_decoder bsd_slave_decoder_chk #(.OEM_EXT(OEM_EXT)) u_chk (
  .mclk(mclk), .nrst(nrst), .homeAddrPin(homeAddrPin), .rxIn(rxIn),
  .txReady(txReady), .statusIn(statusIn), .configIn(configIn),
  .swCommitIn(swCommitIn), .swUncommIn(swUncommIn), .txOut(txOut),
  .standby(standby), .resetFlag(resetFlag), .contention(contention),
  .ctlReset(ctlReset), .curAddr(curAddr));
